// File: core/pbr_pkg.sv
// Purpose: constants for power button and reset pin block
// Assumes: 16-bit registers, one per 32-bit word
// Notes: byte address of a register is four times its index

package pbr_pkg;

	// ----------------------------------------
	// register indices
	// ----------------------------------------
	localparam int unsigned ADDR_W = 18;
	localparam logic [15:0] IDX_BTN_CTRL = 16'h4005;
	localparam logic [15:0] IDX_RST_CTRL = 16'h4006;
	localparam logic [15:0] IDX_SECURITY = 16'h4008;
	localparam logic [15:0] IDX_INT_STS1 = 16'h4011;
	localparam logic [15:0] IDX_INT_MSK1 = 16'h4019;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned BTN_TO_LSB = 0;
	localparam int unsigned BTN_STS_BIT = 3;
	localparam int unsigned BTN_PRI_LSB = 4;
	localparam int unsigned BTN_SEC_LSB = 8;
	localparam int unsigned RESET_RELEASE_DELAY_LSB = 0;
	localparam int unsigned RST_SLP_DRV_BIT = 4;
	localparam int unsigned SLEEP_RESET_INPUT_MASK_BIT = 5;
	localparam int unsigned AUX_SLP_DRV_BIT = 6;
	localparam int unsigned BTN_FLAG_BIT = 12;

	// ----------------------------------------
	// reset values and writable bits
	// ----------------------------------------
	localparam logic [15:0] BTN_CTRL_RST = 16'h0100;
	localparam logic [15:0] BTN_CTRL_WMASK = 16'h0333;
	localparam logic [15:0] RST_CTRL_RST = 16'h0073;
	localparam logic [15:0] RST_CTRL_WMASK = 16'h0073;
	localparam logic [15:0] INT_MSK1_RST = 16'h1000;

	// ----------------------------------------
	// action and power state codes
	// ----------------------------------------
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_ON = 2'h1;
	localparam logic [1:0] ACT_OFF = 2'h2;
	localparam logic [1:0] PS_OFF = 2'h0;
	localparam logic [1:0] PS_ON = 2'h1;
	localparam logic [1:0] PS_SLEEP = 2'h2;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned HOLD_BASE_MS = 1000;
	localparam int unsigned DEBOUNCE_MS = 20;
	localparam logic [6:0] RST_DLY0_MS = 7'h03;
	localparam logic [6:0] RST_DLY1_MS = 7'h0b;
	localparam logic [6:0] RST_DLY2_MS = 7'h33;
	localparam logic [6:0] RST_DLY3_MS = 7'h65;
	localparam logic [2:0] PIN_GUARD = 3'h7;

endpackage : pbr_pkg

// File: core/pbr_filter.sv
// Purpose: pin synchroniser with tick-based debounce
// Assumes: tick_in is a one-cycle enable
// Notes: output changes after DEB ticks of a steady new level

`timescale 1ns/1ps

module pbr_filter #(
	parameter int unsigned DEB = 1
) (
	input wire logic clk_in, // system clock
	input wire logic rst_in, // async reset, high
	input wire logic tick_in, // debounce time step
	input wire logic pin_in, // raw pin level
	output logic level_out // filtered level
);

	logic s1;
	logic s2;
	logic s3;
	logic [15:0] cnt;
	wire moved = (s2 == s3) && (s3 != level_out);
	wire done = (cnt >= 16'(DEB - 1)) && tick_in;

	// ----------------------------------------
	// three stages, then steady-level count
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			cnt <= 16'h0000;
			level_out <= 1'b1;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			if (!moved) begin
				cnt <= 16'h0000;
			end else if (done) begin
				cnt <= 16'h0000;
				level_out <= s3;
			end else if (tick_in) begin
				cnt <= cnt + 16'h0001;
			end
		end
	end

endmodule : pbr_filter

// File: core/pbr_top.sv
// Purpose: power button actions and system reset pin control
// Assumes: power state and transition-done come from the state machine
// Notes: registers on Avalon-MM, one wait cycle per access
//
// Our own choice: register access over Avalon-MM.

`timescale 1ns/1ps

module pbr_top
	import pbr_pkg::*;
#(
	parameter int unsigned MS_CYCLES = pbr_pkg::TICK_CYCLES,
	parameter int unsigned DEB_MS = pbr_pkg::DEBOUNCE_MS,
	parameter int unsigned BASE_MS = pbr_pkg::HOLD_BASE_MS,
	parameter logic [15:0] USER_KEY = 16'h5a3c // arbitrary value
) (
	input wire logic sys_clk_in, // 100 MHz
	input wire logic rst_in, // async reset, high
	input wire logic [pbr_pkg::ADDR_W-1:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [31:0] avs_writedata_in, // write data
	input wire logic [3:0] avs_byteenable_in, // byte lanes
	output logic [31:0] avs_readdata_out, // read data
	output logic avs_waitrequest_out, // stall
	input wire logic button_n_in, // button pin, low pressed
	input wire logic sys_reset_n_in, // reset pin level
	output logic sys_reset_n_out, // reset pin drive value
	output logic sys_reset_oe_out, // reset pin pulled low
	input wire logic [1:0] power_state_in, // current power state
	input wire logic on_done_in, // ON or WAKE finished
	output logic on_req_out, // ON request pulse
	output logic off_req_out, // OFF request pulse
	output logic hw_reset_req_out, // hardware reset pulse
	output logic button_irq_out, // button event interrupt
	output logic on_ind_out, // ON state indicator
	output logic sleep_ind_out, // SLEEP state indicator
	output logic aux_reset_out // auxiliary reset, high
);

	typedef enum logic [3:0] {
		PBR_IDLE = 4'h1,
		PBR_HOLD1 = 4'h2,
		PBR_HOLD2 = 4'h4,
		PBR_DONE = 4'h8
	} pbr_state_t;

	pbr_state_t st;
	pbr_state_t next_st;
	logic [16:0] div;
	logic tick;
	logic btn_deb;
	logic btn_prev;
	logic pin_deb;
	logic [13:0] hold_ms;
	logic [6:0] dly_ms;
	logic dly_run;
	logic released;
	logic [2:0] guard;
	logic ext_prev;
	logic unlocked;
	logic [15:0] btn_ctrl;
	logic [15:0] rst_ctrl;
	logic flag;
	logic mask;

	// ----------------------------------------
	// millisecond timebase
	// ----------------------------------------
	wire tick_wrap = (div == 17'(MS_CYCLES - 1));

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			div <= 17'h00000;
			tick <= 1'b0;
		end else begin
			tick <= (div == 17'(MS_CYCLES - 1));
			div <= tick_wrap ? 17'h00000 : div + 17'h00001;
		end
	end

	// ----------------------------------------
	// pin filters
	// ----------------------------------------
	pbr_filter #(.DEB(DEB_MS)) u_btn (
		.clk_in(sys_clk_in),
		.rst_in(rst_in),
		.tick_in(tick),
		.pin_in(button_n_in),
		.level_out(btn_deb)
	);

	pbr_filter #(.DEB(1)) u_pin (
		.clk_in(sys_clk_in),
		.rst_in(rst_in),
		.tick_in(1'b1),
		.pin_in(sys_reset_n_in),
		.level_out(pin_deb)
	);

	wire btn_fall = btn_prev & ~btn_deb;
	wire btn_rise = ~btn_prev & btn_deb;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire [15:0] idx = 16'(avs_address_in >> 2);
	wire req = avs_read_in | avs_write_in;
	wire wr_go = avs_write_in & ~avs_waitrequest_out;
	wire [15:0] bem = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	wire [15:0] wd = avs_writedata_in[15:0] & bem;
	wire sel_btn = idx == IDX_BTN_CTRL;
	wire sel_rst = idx == IDX_RST_CTRL;
	wire sel_sec = idx == IDX_SECURITY;
	wire sel_sts = idx == IDX_INT_STS1;
	wire sel_msk = idx == IDX_INT_MSK1;
	wire wr_btn = wr_go & sel_btn & unlocked;
	wire wr_rst = wr_go & sel_rst & unlocked;
	wire wr_sec = wr_go & sel_sec & avs_byteenable_in[0] & avs_byteenable_in[1];
	wire clr_flag = wr_go & sel_sts & wd[BTN_FLAG_BIT];
	wire wr_msk = wr_go & sel_msk & bem[BTN_FLAG_BIT];
	wire [15:0] btn_wm = BTN_CTRL_WMASK & bem;
	wire [15:0] rst_wm = RST_CTRL_WMASK & bem;
	wire [15:0] btn_view = {btn_ctrl[15:4], btn_deb, btn_ctrl[2:0]};
	wire [15:0] rd_val = sel_btn ? btn_view :
		sel_rst ? rst_ctrl :
		sel_sec ? {15'h0000, unlocked} :
		sel_sts ? 16'(flag) << BTN_FLAG_BIT :
		sel_msk ? 16'(mask) << BTN_FLAG_BIT : 16'h0000;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	wire [1:0] hold_to = btn_ctrl[BTN_TO_LSB +: 2];
	wire [1:0] pri_act = btn_ctrl[BTN_PRI_LSB +: 2];
	wire [1:0] sec_act = btn_ctrl[BTN_SEC_LSB +: 2];
	wire [1:0] dly_sel = rst_ctrl[RESET_RELEASE_DELAY_LSB +: 2];
	wire slp_drv = rst_ctrl[RST_SLP_DRV_BIT];
	wire slp_msk = rst_ctrl[SLEEP_RESET_INPUT_MASK_BIT];
	wire aux_drv = rst_ctrl[AUX_SLP_DRV_BIT];
	wire st_on = power_state_in == PS_ON;
	wire st_sleep = power_state_in == PS_SLEEP;
	wire st_off = power_state_in == PS_OFF;

	// ----------------------------------------
	// hold timing
	// ----------------------------------------
	wire [13:0] to_ms = 14'(BASE_MS) << hold_to;
	wire expire = tick && (hold_ms == to_ms - 14'h0001);
	wire sec_fire = (st == PBR_HOLD1) && expire && !btn_rise;
	wire ter_fire = (st == PBR_HOLD2) && expire && !btn_rise;

	always_comb begin
		next_st = st;
		case (st)
			PBR_IDLE: begin
				if (btn_fall) begin
					next_st = PBR_HOLD1;
				end
			end
			PBR_HOLD1: begin
				if (btn_rise) begin
					next_st = PBR_IDLE;
				end else if (expire) begin
					next_st = PBR_HOLD2;
				end
			end
			PBR_HOLD2: begin
				if (btn_rise) begin
					next_st = PBR_IDLE;
				end else if (expire) begin
					next_st = PBR_DONE;
				end
			end
			PBR_DONE: begin
				if (btn_rise) begin
					next_st = PBR_IDLE;
				end
			end
			default: begin
				next_st = PBR_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// reset pin handling
	// ----------------------------------------
	wire [6:0] dly_len = (dly_sel == 2'h0) ? RST_DLY0_MS :
		(dly_sel == 2'h1) ? RST_DLY1_MS :
		(dly_sel == 2'h2) ? RST_DLY2_MS : RST_DLY3_MS;
	wire dly_end = dly_run && tick && (dly_ms == dly_len - 7'h01);
	wire drive_rst = st_off | (st_sleep & slp_drv) | (st_on & ~released);
	// guard skips the pin echo after our own drive stops
	wire ext_low = ~pin_deb && (guard == PIN_GUARD) && !(st_sleep && slp_msk);
	wire ext_hit = ext_low & ~ext_prev;

	// ----------------------------------------
	// bus slave and registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h00000000;
		end else begin
			avs_waitrequest_out <= ~(req & avs_waitrequest_out);
			if (avs_read_in & avs_waitrequest_out) begin
				avs_readdata_out <= {16'h0000, rd_val};
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			unlocked <= 1'b0;
			btn_ctrl <= BTN_CTRL_RST;
			rst_ctrl <= RST_CTRL_RST;
			mask <= 1'b1;
		end else if (ext_hit) begin
			unlocked <= 1'b0;
			btn_ctrl <= BTN_CTRL_RST;
			rst_ctrl <= RST_CTRL_RST;
			mask <= 1'b1;
		end else begin
			if (wr_sec) begin
				unlocked <= wd == USER_KEY;
			end
			if (wr_btn) begin
				btn_ctrl <= (btn_ctrl & ~btn_wm) | (wd & btn_wm);
			end
			if (wr_rst) begin
				rst_ctrl <= (rst_ctrl & ~rst_wm) | (wd & rst_wm);
			end
			if (wr_msk) begin
				mask <= wd[BTN_FLAG_BIT];
			end
		end
	end

	// ----------------------------------------
	// button actions and flag
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= PBR_IDLE;
			btn_prev <= 1'b1;
			hold_ms <= 14'h0000;
			flag <= 1'b0;
			on_req_out <= 1'b0;
			off_req_out <= 1'b0;
		end else begin
			st <= next_st;
			btn_prev <= btn_deb;
			hold_ms <= (btn_fall || expire) ? 14'h0000 : hold_ms + 14'(tick);
			// set wins over the clear
			if (btn_fall || btn_rise || (sec_fire && sec_act == ACT_NONE)) begin
				flag <= 1'b1;
			end else if (clr_flag) begin
				flag <= 1'b0;
			end
			on_req_out <= (btn_fall && pri_act == ACT_ON) || (sec_fire && sec_act == ACT_ON);
			off_req_out <= (btn_fall && pri_act == ACT_OFF) || (sec_fire && sec_act == ACT_OFF) ||
				ter_fire;
		end
	end

	// ----------------------------------------
	// pin outputs
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			dly_ms <= 7'h00;
			dly_run <= 1'b0;
			released <= 1'b0;
			guard <= 3'h0;
			ext_prev <= 1'b0;
			sys_reset_n_out <= 1'b0;
			sys_reset_oe_out <= 1'b1;
			hw_reset_req_out <= 1'b0;
			button_irq_out <= 1'b0;
			on_ind_out <= 1'b0;
			sleep_ind_out <= 1'b0;
			aux_reset_out <= 1'b1;
		end else begin
			if (!st_on) begin
				released <= 1'b0;
				dly_run <= 1'b0;
			end else if (on_done_in && !released) begin
				dly_run <= 1'b1;
				dly_ms <= 7'h00;
			end else if (dly_end) begin
				dly_run <= 1'b0;
				released <= 1'b1;
			end else if (dly_run) begin
				dly_ms <= dly_ms + 7'(tick);
			end
			guard <= sys_reset_oe_out ? 3'h0 : guard + 3'(guard != PIN_GUARD);
			ext_prev <= ext_low;
			sys_reset_n_out <= 1'b0;
			sys_reset_oe_out <= drive_rst;
			hw_reset_req_out <= ext_hit;
			button_irq_out <= flag & ~mask;
			on_ind_out <= st_on;
			sleep_ind_out <= st_sleep;
			aux_reset_out <= st_off | (st_sleep & aux_drv);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_on_indicator: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		st_on |=> on_ind_out && !sleep_ind_out)
		else $error("on indicator wrong");

	a_sleep_indicator: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		st_sleep |=> sleep_ind_out && !on_ind_out)
		else $error("sleep indicator wrong");

	a_primary_on: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		btn_fall && pri_act == ACT_ON |=> on_req_out && !off_req_out)
		else $error("primary on request missing");

	a_edge_flag: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		$changed(btn_deb) |=> flag)
		else $error("button edge did not set flag");

	a_flag_sticky: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		flag && !clr_flag && !ext_hit |=> flag)
		else $error("flag lost without clear");

	a_irq_gate: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		mask |=> !button_irq_out)
		else $error("masked interrupt seen");

	a_tertiary_off: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		ter_fire |=> off_req_out ##1 !off_req_out)
		else $error("tertiary off request wrong");

	a_release_cancel: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		btn_rise |=> st == PBR_IDLE ##1 !on_req_out && !off_req_out)
		else $error("release did not cancel");

	a_reset_off: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		st_off |=> sys_reset_oe_out && !sys_reset_n_out && aux_reset_out)
		else $error("reset not driven in off");

	a_lock_hold: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		!unlocked && !ext_hit |=> $stable(btn_ctrl) && $stable(rst_ctrl))
		else $error("locked control changed");

	a_delay_hold: assert property (
		@(posedge sys_clk_in) disable iff (rst_in)
		st_on && on_done_in && !released |=> dly_run ##1 sys_reset_oe_out)
		else $error("reset released early");

endmodule : pbr_top

// File: verif/pbr_partner.sv
// Purpose: power switch and system reset wire model
// Assumes: pull-ups on the button wire and the reset wire
// Notes: ext_pull_in stands for an outside reset source

`timescale 1ns/1ps

module pbr_partner (
	input wire logic press_in, // switch closed
	input wire logic ext_pull_in, // outside source pulls reset low
	input wire logic drv_in, // block drive value
	input wire logic oe_in, // block pulls the pin
	output logic button_n_out, // button wire level
	output logic reset_n_out // reset wire level
);
	// ----------------------------------------
	// wire levels
	// ----------------------------------------
	assign button_n_out = press_in ? 1'b0 : 1'b1;
	assign reset_n_out = ((oe_in && !drv_in) || ext_pull_in) ? 1'b0 : 1'b1;
endmodule : pbr_partner

// File: verif/pbr_top_tb.sv
// Purpose: self-checking bench for the button and reset pin block
// Assumes: shortened ms tick, debounce and hold base
// Notes: every wait is bounded

`timescale 1ns/1ps

module pbr_top_tb;
	import pbr_pkg::*;
	localparam logic [15:0] KEY = 16'h5a3c; // arbitrary value
	logic sys_clk, rst, rd, wr_s, waitreq, btn_n, rst_wire, rst_drv, rst_oe;
	logic on_done, on_req, off_req, hw_req, irq, on_ind, sleep_ind, aux, press, ext_pull;
	logic [ADDR_W-1:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] be;
	logic [1:0] ps;
	int n_errors = 0;
	int samples_checked = 0;

	pbr_top #(.MS_CYCLES(10), .DEB_MS(2), .BASE_MS(4), .USER_KEY(KEY)) i_pbr_top (
		.sys_clk_in(sys_clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
		.avs_write_in(wr_s), .avs_writedata_in(wdata), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .button_n_in(btn_n),
		.sys_reset_n_in(rst_wire), .sys_reset_n_out(rst_drv), .sys_reset_oe_out(rst_oe),
		.power_state_in(ps), .on_done_in(on_done), .on_req_out(on_req), .off_req_out(off_req),
		.hw_reset_req_out(hw_req), .button_irq_out(irq), .on_ind_out(on_ind),
		.sleep_ind_out(sleep_ind), .aux_reset_out(aux));

	pbr_partner i_pbr_partner (.press_in(press), .ext_pull_in(ext_pull), .drv_in(rst_drv),
		.oe_in(rst_oe), .button_n_out(btn_n), .reset_n_out(rst_wire));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	// request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] d, output logic [15:0] q);
		int k;
		k = 0;
		addr <= {idx, 2'h0};
		wdata <= {16'h0000, d};
		wr_s <= w;
		rd <= !w;
		do begin
			@(posedge sys_clk);
			k++;
		end while (waitreq !== 1'b0 && k < 50);
		q = rdata[15:0];
		wr_s <= 1'b0;
		rd <= 1'b0;
		if (waitreq !== 1'b0) begin
			n_errors++;
			results();
		end
		@(posedge sys_clk);
	endtask : bus

	task automatic wr(input logic [15:0] idx, input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, idx, d, q);
	endtask : wr

	task automatic rdchk(input logic [15:0] idx, input logic [15:0] exp);
		logic [15:0] q;
		bus(1'b0, idx, 16'h0000, q);
		check(q, exp);
	endtask : rdchk

	function automatic logic sig(input int s);
		return s == 0 ? on_req : (s == 1 ? off_req : hw_req);
	endfunction : sig

	task automatic wait_sig(input int s, input int max, output int cyc);
		cyc = 0;
		do begin
			@(posedge sys_clk);
			cyc++;
		end while (sig(s) !== 1'b1 && cyc < max);
		if (sig(s) !== 1'b1) begin
			n_errors++;
			results();
		end
	endtask : wait_sig

	task automatic quiet(input int s, input int n);
		int hits;
		hits = 0;
		repeat (n) begin
			@(posedge sys_clk);
			if (sig(s) !== 1'b0) hits++;
		end
		check(hits, 0);
	endtask : quiet

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdchk(IDX_BTN_CTRL, 16'h0108);
		rdchk(IDX_RST_CTRL, 16'h0073);
		rdchk(IDX_INT_MSK1, 16'h1000);
		rdchk(IDX_INT_STS1, 16'h0000);
		rdchk(16'h4000, 16'h0000);
		check({rst_oe, aux}, 2'b11);
		$display("test reset done");
	endtask : t_reset

	task automatic t_lock;
		wr(IDX_BTN_CTRL, 16'h0111);
		rdchk(IDX_BTN_CTRL, 16'h0108);
		wr(IDX_SECURITY, KEY);
		wr(IDX_BTN_CTRL, 16'h0111);
		rdchk(IDX_BTN_CTRL, 16'h0119);
		$display("test lock done");
	endtask : t_lock

	task automatic t_states;
		logic [1:0] ps_t [4] = '{PS_OFF, PS_SLEEP, PS_SLEEP, PS_ON};
		logic [15:0] rc_t [4] = '{16'h0033, 16'h0033, 16'h0063, 16'h0063};
		logic [3:0] ex_t [4] = '{4'b0011, 4'b0101, 4'b0110, 4'b1001};
		for (int i = 0; i < 4; i++) begin
			wr(IDX_RST_CTRL, rc_t[i]);
			ps <= ps_t[i];
			tick(3);
			check({on_ind, sleep_ind, aux, rst_oe}, ex_t[i]);
		end
		$display("test states done");
	endtask : t_states

	task automatic t_delay;
		int ms_t [4] = '{3, 11, 51, 101};
		int n;
		for (int d = 0; d < 4; d++) begin
			wr(IDX_RST_CTRL, 16'h0060 | 16'(d));
			ps <= PS_OFF;
			tick(3);
			ps <= PS_ON;
			tick(2);
			on_done <= 1'b1;
			tick(1);
			on_done <= 1'b0;
			n = 0;
			while (rst_oe === 1'b1 && n < 1100) begin
				@(posedge sys_clk);
				n++;
			end
			check(n >= ms_t[d] * 10 - 10 && n <= ms_t[d] * 10 + 5, 1);
		end
		$display("test delay done");
	endtask : t_delay

	task automatic t_button;
		int n;
		wr(IDX_INT_MSK1, 16'h0000);
		press <= 1'b1;
		wait_sig(0, 200, n);
		check(n >= 10, 1);
		wait_sig(0, 200, n);
		check(n >= 70 && n <= 91, 1);
		wait_sig(1, 200, n);
		check(n >= 70 && n <= 91, 1);
		rdchk(IDX_BTN_CTRL, 16'h0111);
		check(irq, 1'b1);
		rdchk(IDX_INT_STS1, 16'h1000);
		wr(IDX_INT_STS1, 16'h1000);
		rdchk(IDX_INT_STS1, 16'h0000);
		press <= 1'b0;
		tick(60);
		rdchk(IDX_INT_STS1, 16'h1000);
		wr(IDX_INT_MSK1, 16'h1000);
		tick(2);
		check(irq, 1'b0);
		wr(IDX_INT_STS1, 16'h1000);
		$display("test button done");
	endtask : t_button

	task automatic t_cancel;
		int n;
		wr(IDX_BTN_CTRL, 16'h0221);
		press <= 1'b1;
		tick(5);
		press <= 1'b0;
		quiet(1, 60);
		press <= 1'b1;
		wait_sig(1, 200, n);
		tick(20);
		press <= 1'b0;
		quiet(1, 200);
		// primary ignore, secondary sets the event flag
		wr(IDX_BTN_CTRL, 16'h0001);
		wr(IDX_INT_STS1, 16'h1000);
		press <= 1'b1;
		tick(40);
		wr(IDX_INT_STS1, 16'h1000);
		rdchk(IDX_INT_STS1, 16'h0000);
		quiet(0, 90);
		rdchk(IDX_INT_STS1, 16'h1000);
		press <= 1'b0;
		tick(40);
		wr(IDX_INT_STS1, 16'h1000);
		$display("test cancel done");
	endtask : t_cancel

	task automatic t_ext;
		int n;
		ps <= PS_SLEEP;
		tick(3);
		ext_pull <= 1'b1;
		quiet(2, 40);
		ext_pull <= 1'b0;
		tick(10);
		wr(IDX_RST_CTRL, 16'h0043);
		tick(10);
		ext_pull <= 1'b1;
		wait_sig(2, 50, n);
		ext_pull <= 1'b0;
		tick(5);
		rdchk(IDX_RST_CTRL, 16'h0073);
		wr(IDX_BTN_CTRL, 16'h0111);
		rdchk(IDX_BTN_CTRL, 16'h0108);
		$display("test external reset done");
	endtask : t_ext

	// ----------------------------------------
	// clock and main sequence
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		rst = 1'b1;
		addr = '0;
		rd = 1'b0;
		wr_s = 1'b0;
		wdata = 32'h0;
		be = 4'hf;
		ps = PS_OFF;
		on_done = 1'b0;
		press = 1'b0;
		ext_pull = 1'b0;
		tick(20);
		rst <= 1'b0;
		tick(1);
		t_reset();
		t_lock();
		t_states();
		t_delay();
		t_button();
		t_cancel();
		t_ext();
		results();
	end
endmodule : pbr_top_tb
